// ### hw/oest_pkg.sv
// Package with register map, field layout, reset values and codes of the oscillator control block.
package oest_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 10;
    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_CTRL3 = 10'h28f;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h290;
    localparam logic [IDX_W-1:0] IDX_ENABLE = 10'h291;
    localparam logic [IDX_W-1:0] IDX_TRIM = 10'h292;
    localparam logic [IDX_W-1:0] IDX_FREQ = 10'h293;
    localparam logic [IDX_W-1:0] IDX_TUNECTL = 10'h294;
    // Source bit positions, shared by status and enable registers.
    localparam int BIT_EXT = 7;
    localparam int BIT_FAST = 6;
    localparam int BIT_MID = 5;
    localparam int BIT_SLOW = 4;
    localparam int BIT_SEC = 3;
    localparam int BIT_CONV = 2;
    localparam int BIT_START = 1;
    localparam int BIT_PLL = 0;
    localparam int BIT_POWER = 6;
    localparam int BIT_TUNE_ON = 7;
    localparam int BIT_TUNE_HOLD = 6;
    localparam int TRIM_W = 6;
    localparam int FREQ_W = 3;
    localparam int MHZ_W = 6;
    localparam logic [7:0] ENABLE_MASK = 8'hfd;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h00;
    localparam logic [TRIM_W-1:0] TRIM_MAX = 6'h1f;
    localparam logic [TRIM_W-1:0] TRIM_MIN = 6'h20;
    localparam logic [FREQ_W-1:0] FREQ_RESET = 3'h0;
    localparam logic POWER_RESET = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        OEST_F1 = 3'b000,
        OEST_F2 = 3'b001,
        OEST_F4 = 3'b010,
        OEST_F8 = 3'b011,
        OEST_F16 = 3'b100,
        OEST_F32 = 3'b101,
        OEST_RSV6 = 3'b110,
        OEST_RSV7 = 3'b111
    } oest_freq_type;
endpackage

// ### hw/oest_source_gate.sv
// Run request and ready flag logic for a group of clock sources.
`timescale 1ns/1ps
module oest_source_gate #(
    parameter int N = 7
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Demand for each source.
    input wire logic [N-1:0] force_on,
    input wire logic [N-1:0] periph_req,
    input wire logic [N-1:0] sys_sel,
    // Oscillator feedback.
    input wire logic [N-1:0] osc_ready,
    // Results.
    output logic [N-1:0] run_req,
    output logic [N-1:0] ready_flag
);
    wire logic [N-1:0] next_run_req;
    wire logic [N-1:0] next_ready_flag;

    // A source runs while forced on or requested, and stops once nobody asks for it.
    assign next_run_req = force_on | periph_req | sys_sel;
    // Ready is shown only while the source is requested and reports ready.
    assign next_ready_flag = run_req & osc_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_req <= '0;
            ready_flag <= '0;
        end else begin
            run_req <= next_run_req;
            ready_flag <= next_ready_flag;
        end
    end
endmodule

// ### hw/oest_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into single-cycle register strobes.
`timescale 1ns/1ps
module oest_axil_slave
    import oest_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite bus.
    input wire logic [ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [DATA_W-1:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [DATA_W-1:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Register side.
    output logic wr_en,
    output logic [IDX_W-1:0] wr_idx,
    output logic [DATA_W-1:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_hit,
    output logic rd_en,
    output logic [IDX_W-1:0] rd_idx,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic rd_hit
);
    wire logic aw_hs;
    wire logic w_hs;
    wire logic b_hs;
    wire logic ar_hs;
    wire logic r_hs;
    logic [IDX_W-1:0] aw_idx;

    assign aw_hs = s_awvalid & s_awready;
    assign w_hs = s_wvalid & s_wready;
    assign b_hs = s_bvalid & s_bready;
    assign ar_hs = s_arvalid & s_arready;
    assign r_hs = s_rvalid & s_rready;
    // Address and data may arrive in either order; the write fires once both are held.
    assign wr_en = ~s_awready & ~s_wready & ~s_bvalid;
    assign wr_idx = aw_idx;
    assign rd_en = ar_hs;
    assign rd_idx = s_araddr[ADDR_W-1:2];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
            aw_idx <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else begin
            if (aw_hs) begin
                s_awready <= 1'b0;
                aw_idx <= s_awaddr[ADDR_W-1:2];
            end
            if (w_hs) begin
                s_wready <= 1'b0;
                wr_data <= s_wdata;
                wr_strb <= s_wstrb;
            end
            if (wr_en) begin
                s_bvalid <= 1'b1;
                s_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (b_hs) begin
                s_bvalid <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= RESP_OKAY;
        end else if (ar_hs) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata <= rd_hit ? rd_data : '0;
            s_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (r_hs) begin
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
        end
    end
endmodule

// ### hw/oest_top.sv
// Oscillator enable, ready status and frequency tuning registers with source run control.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module oest_top
    import oest_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite register bus.
    input wire logic [ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [DATA_W-1:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [DATA_W-1:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Demand from peripherals and from the system clock selection, bits 7 to 1 per source.
    input wire logic [7:1] periph_req,
    input wire logic [7:1] sys_clk_sel,
    // Feedback from the oscillator circuits.
    input wire logic [7:1] osc_ready,
    input wire logic pll_locked,
    // External oscillator mode from configuration.
    input wire logic [2:0] ext_osc_mode_config,
    // Automatic tuning engine.
    input wire logic [TRIM_W-1:0] tune_value,
    input wire logic tune_update,
    // Oscillator controls.
    output logic [7:1] osc_run,
    output logic pll_run,
    output logic periph_ext_use_pll,
    output logic [2:0] ext_osc_mode,
    output logic secondary_power_sel,
    output logic [TRIM_W-1:0] freq_trim,
    output logic [FREQ_W-1:0] nominal_freq_sel,
    output logic [MHZ_W-1:0] nominal_freq_mhz,
    output logic auto_tune_on,
    output logic auto_tune_update_hold
);
    // Nominal frequency in MHz for a select code; reserved codes give zero.
    function automatic logic [MHZ_W-1:0] freq_mhz(input logic [FREQ_W-1:0] code);
        logic [MHZ_W-1:0] mhz;
        mhz = '0;
        case (oest_freq_type'(code))
            OEST_F1: mhz = 6'h01;
            OEST_F2: mhz = 6'h02;
            OEST_F4: mhz = 6'h04;
            OEST_F8: mhz = 6'h08;
            OEST_F16: mhz = 6'h10;
            OEST_F32: mhz = 6'h20;
            default: mhz = '0;
        endcase
        return mhz;
    endfunction

    // A code above the largest documented one is reserved.
    function automatic logic freq_code_ok(input logic [FREQ_W-1:0] code);
        return code <= FREQ_W'(OEST_F32);
    endfunction

    wire logic wr_en;
    wire logic [IDX_W-1:0] wr_idx;
    wire logic [DATA_W-1:0] wr_data;
    wire logic [3:0] wr_strb;
    wire logic rd_en;
    wire logic [IDX_W-1:0] rd_idx;
    logic [DATA_W-1:0] rd_data;
    wire logic wr_hit;
    wire logic rd_hit;

    logic [7:0] force_enable;
    logic [7:0] ready_status;
    wire logic [7:1] src_run;
    wire logic [7:1] src_ready;
    logic pll_ready;

    wire logic lane0;
    wire logic wr_ctrl3;
    wire logic wr_enable;
    wire logic wr_trim;
    wire logic wr_freq;
    wire logic wr_tunectl;
    wire logic hw_trim_load;
    wire logic [7:0] next_force_enable;
    wire logic [7:1] source_force;
    wire logic next_pll_run;
    wire logic next_pll_ready;
    wire logic [7:0] next_ready_status;

    oest_axil_slave u_bus (
        .clk(clk),
        .rst(rst),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_hit(wr_hit),
        .rd_en(rd_en),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // Address decode.
    assign wr_hit = (wr_idx >= IDX_CTRL3) && (wr_idx <= IDX_TUNECTL);
    assign rd_hit = (rd_idx >= IDX_CTRL3) && (rd_idx <= IDX_TUNECTL);
    // All fields live in byte lane 0; a write without that lane changes nothing.
    assign lane0 = wr_en & wr_strb[0];
    assign wr_ctrl3 = lane0 && (wr_idx == IDX_CTRL3);
    assign wr_enable = lane0 && (wr_idx == IDX_ENABLE);
    assign wr_trim = lane0 && (wr_idx == IDX_TRIM);
    assign wr_freq = lane0 && (wr_idx == IDX_FREQ) && freq_code_ok(wr_data[FREQ_W-1:0]);
    assign wr_tunectl = lane0 && (wr_idx == IDX_TUNECTL);
    // A status write is accepted on the bus and has no effect.
    assign next_force_enable = wr_data[7:0] & ENABLE_MASK;

    // Hardware tuning updates take the trim while enabled and not held.
    assign hw_trim_load = auto_tune_on & ~auto_tune_update_hold & tune_update;

    // Forced sources, bit 1 has no enable and runs only on demand.
    assign source_force = {force_enable[BIT_EXT],
                           force_enable[BIT_FAST],
                           force_enable[BIT_MID],
                           force_enable[BIT_SLOW],
                           force_enable[BIT_SEC],
                           force_enable[BIT_CONV],
                           1'b0};

    oest_source_gate #(
        .N(7)
    ) u_sources (
        .clk(clk),
        .rst(rst),
        .force_on(source_force),
        .periph_req(periph_req),
        .sys_sel(sys_clk_sel),
        .osc_ready(osc_ready),
        .run_req(src_run),
        .ready_flag(src_ready)
    );

    // The multiplier runs only when enabled and a peripheral asks for the external clock.
    assign next_pll_run = force_enable[BIT_PLL] & periph_req[BIT_EXT];
    // Ready needs the multiplier on, its input source ready and lock reported.
    assign next_pll_ready = pll_run & src_ready[BIT_EXT] & pll_locked;

    assign next_ready_status = {src_ready[BIT_EXT],
                                src_ready[BIT_FAST],
                                src_ready[BIT_MID],
                                src_ready[BIT_SLOW],
                                src_ready[BIT_SEC],
                                src_ready[BIT_CONV],
                                src_ready[BIT_START],
                                pll_ready};

    // Status is loaded from hardware only; bus writes never reach it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_status <= STATUS_RESET;
            pll_ready <= 1'b0;
            pll_run <= 1'b0;
        end else begin
            ready_status <= next_ready_status;
            pll_ready <= next_pll_ready;
            pll_run <= next_pll_run;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            force_enable <= ENABLE_RESET;
        end else if (wr_enable) begin
            force_enable <= next_force_enable;
        end
    end

    // A hardware tuning update wins over a software write in the same cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_trim <= TRIM_RESET;
        end else if (hw_trim_load) begin
            freq_trim <= tune_value;
        end else if (wr_trim) begin
            freq_trim <= wr_data[TRIM_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nominal_freq_sel <= FREQ_RESET;
            nominal_freq_mhz <= freq_mhz(FREQ_RESET);
        end else if (wr_freq) begin
            nominal_freq_sel <= wr_data[FREQ_W-1:0];
            nominal_freq_mhz <= freq_mhz(wr_data[FREQ_W-1:0]);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            secondary_power_sel <= POWER_RESET;
        end else if (wr_ctrl3) begin
            secondary_power_sel <= wr_data[BIT_POWER];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            auto_tune_on <= 1'b0;
            auto_tune_update_hold <= 1'b0;
        end else if (wr_tunectl) begin
            auto_tune_on <= wr_data[BIT_TUNE_ON];
            auto_tune_update_hold <= wr_data[BIT_TUNE_HOLD];
        end
    end

    // Oscillator drive. The multiplier choice steers the peripheral external clock path and also gates the multiplier run.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_run <= '0;
            periph_ext_use_pll <= 1'b0;
            ext_osc_mode <= 3'h0;
        end else begin
            osc_run <= src_run;
            periph_ext_use_pll <= force_enable[BIT_PLL];
            ext_osc_mode <= ext_osc_mode_config;
        end
    end

    // Read mux; unused bits read as zero.
    always_comb begin
        rd_data = '0;
        if (rd_en) begin
            case (rd_idx)
                IDX_CTRL3: rd_data[BIT_POWER] = secondary_power_sel;
                IDX_STATUS: rd_data[7:0] = ready_status;
                IDX_ENABLE: rd_data[7:0] = force_enable;
                IDX_TRIM: rd_data[TRIM_W-1:0] = freq_trim;
                IDX_FREQ: rd_data[FREQ_W-1:0] = nominal_freq_sel;
                IDX_TUNECTL: begin
                    rd_data[BIT_TUNE_ON] = auto_tune_on;
                    rd_data[BIT_TUNE_HOLD] = auto_tune_update_hold;
                end
                default: rd_data = '0;
            endcase
        end
    end
endmodule

// ### verification/oest_top_asserts.sv
// Checker of bus answers, source demand, status flags and tuning outputs of the oscillator control block.
`timescale 1ns/1ps
module oest_checker
    import oest_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register bus.
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic [1:0] s_bresp,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [DATA_W-1:0] s_rdata,
    input wire logic s_rvalid,
    // Sources.
    input wire logic [7:1] periph_req,
    input wire logic [7:1] sys_clk_sel,
    input wire logic [7:1] osc_ready,
    input wire logic pll_locked,
    input wire logic [7:1] osc_run,
    input wire logic pll_run,
    input wire logic periph_ext_use_pll,
    // Tuning.
    input wire logic [TRIM_W-1:0] tune_value,
    input wire logic tune_update,
    input wire logic [TRIM_W-1:0] freq_trim,
    input wire logic [FREQ_W-1:0] nominal_freq_sel,
    input wire logic [MHZ_W-1:0] nominal_freq_mhz,
    input wire logic auto_tune_on,
    input wire logic auto_tune_update_hold
);
    logic [1:0] up;
    logic stat_rd;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Counts the first edges after reset so that history from before the release is not judged.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up <= 2'h0;
            stat_rd <= 1'b0;
        end else begin
            if (up != 2'h3) up <= up + 2'h1;
            if (s_arvalid && s_arready) stat_rd <= s_araddr[11:2] == IDX_STATUS;
        end
    end
    a_run_follows_demand: assert property (up == 2'h3 |->
        (osc_run & ($past(periph_req, 2) | $past(sys_clk_sel, 2))) == ($past(periph_req, 2) | $past(sys_clk_sel, 2)))
        else $error("source not running two cycles after demand");
    a_status_needs_ready: assert property ($rose(s_rvalid) && stat_rd |->
        (s_rdata[7:1] & ~($past(osc_ready) | $past(osc_ready, 2) | $past(osc_ready, 3) | $past(osc_ready, 4))) == 7'h00)
        else $error("ready flag set without oscillator ready");
    a_pll_needs_lock: assert property ($rose(s_rvalid) && stat_rd && s_rdata[0] |->
        $past(pll_locked) || $past(pll_locked, 2) || $past(pll_locked, 3) || $past(pll_locked, 4))
        else $error("multiplier flag set without lock");
    a_pll_needs_demand: assert property (up == 2'h3 && pll_run |->
        $past(periph_req[7]) && ($past(periph_ext_use_pll) || periph_ext_use_pll))
        else $error("multiplier runs without enable and demand");
    a_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read data late");
    a_busy_refuses: assert property (s_bvalid |-> !s_awready && !s_wready)
        else $error("write accepted during response");
    a_freq_map: assert property (up == 2'h3 && $stable(nominal_freq_sel) |->
        nominal_freq_mhz == (6'h01 << nominal_freq_sel))
        else $error("nominal frequency does not match code");
    a_freq_legal: assert property (nominal_freq_sel <= 3'h5)
        else $error("reserved frequency code held");
    a_auto_trim: assert property (tune_update && auto_tune_on && !auto_tune_update_hold |=>
        freq_trim == $past(tune_value))
        else $error("trim not taken from tuning engine");
    c_slverr: cover property (s_bvalid && s_bresp == RESP_SLVERR);
    c_pll_locked: cover property (pll_run && pll_locked);
    c_auto_tune: cover property (tune_update && auto_tune_on);
endmodule

// ### verification/oest_osc_model.sv
// Behavioural oscillator circuits that report ready some cycles after being told to run.
`timescale 1ns/1ps
module oest_osc_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Start-up speed: low starts quickly, high slowly.
    input wire logic slow,
    // Run requests.
    input wire logic [7:1] osc_run,
    input wire logic pll_run,
    // Feedback.
    output logic [7:1] osc_ready,
    output logic pll_locked
);
    logic [2:0] cnt [0:7];
    logic [7:0] run;
    logic [2:0] need;
    // The multiplier can only lock while its external input is ready.
    assign run = {osc_run, pll_run & osc_ready[7]};
    assign need = slow ? 3'h6 : 3'h2;
    always_ff @(posedge clk or posedge rst) begin
        for (int i = 0; i < 8; i++) begin
            if (rst || !run[i]) begin
                cnt[i] <= 3'h0;
            end else if (cnt[i] != 3'h7) begin
                cnt[i] <= cnt[i] + 3'h1;
            end
        end
    end
    always_comb begin
        for (int i = 1; i < 8; i++) begin
            osc_ready[i] = run[i] && cnt[i] >= need;
        end
        pll_locked = run[0] && cnt[0] >= need;
    end
endmodule

// ### verification/testbench.sv
// Self-checking bench of the oscillator control block with an oscillator model on its far side.
`timescale 1ns/1ps
module testbench;
    import oest_pkg::*;
    typedef struct {
        logic [IDX_W-1:0] idx;
        logic [7:0] wr;
        logic [7:0] rd;
        logic [1:0] resp;
        logic [MHZ_W-1:0] mhz;
    } oest_row_type;
    logic clk, rst, slow, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready, pll_locked, pll_run, periph_ext_use_pll;
    logic secondary_power_sel, tune_update, auto_tune_on, auto_tune_update_hold;
    logic [ADDR_W-1:0] s_awaddr, s_araddr;
    logic [DATA_W-1:0] s_wdata, s_rdata, rd;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, resp;
    logic [7:1] periph_req, sys_clk_sel, osc_ready, osc_run, exp7;
    logic [2:0] ext_osc_mode_config, ext_osc_mode, nominal_freq_sel;
    logic [TRIM_W-1:0] tune_value, freq_trim;
    logic [MHZ_W-1:0] nominal_freq_mhz;
    int failures = 0;
    int total_checks = 0;
    oest_row_type rows [14];
    oest_top u_oest_top (.clk, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
        .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
        .periph_req, .sys_clk_sel, .osc_ready, .pll_locked, .ext_osc_mode_config, .tune_value, .tune_update,
        .osc_run, .pll_run, .periph_ext_use_pll, .ext_osc_mode, .secondary_power_sel, .freq_trim,
        .nominal_freq_sel, .nominal_freq_mhz, .auto_tune_on, .auto_tune_update_hold);
    oest_osc_model u_oest_osc_model (.clk, .rst, .slow, .osc_run, .pll_run, .osc_ready, .pll_locked);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        @(posedge clk);
        s_awaddr <= {idx, 2'b00};
        s_wdata <= {24'h000000, d};
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        resp = s_bresp;
        s_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [IDX_W-1:0] idx);
        @(posedge clk);
        s_araddr <= {idx, 2'b00};
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        rd = s_rdata;
        resp = s_rresp;
        s_rready <= 1'b0;
    endtask
    task automatic reset_dut;
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic check_reset;
        for (int i = 0; i < 6; i++) begin
            rd_reg(IDX_CTRL3 + i[IDX_W-1:0]);
            chk("reset value", i == 0 ? 32'h40 : 32'h0, rd);
        end
        chk("power select", 1, secondary_power_sel);
        chk("reset frequency", 1, nominal_freq_mhz);
        chk("reset code", 0, nominal_freq_sel);
        chk("reset run", 0, {osc_run, pll_run});
    endtask
    task automatic pulse_tune(input logic [TRIM_W-1:0] v);
        tune_value <= v;
        tune_update <= 1'b1;
        @(posedge clk);
        tune_update <= 1'b0;
        rd_reg(IDX_TRIM);
    endtask
    task automatic results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #100us;
        failures++;
        results();
    end
    initial begin
        rows = '{'{IDX_STATUS, 8'hff, 8'h00, RESP_OKAY, 6'h01}, '{IDX_TRIM, 8'h1f, 8'h1f, RESP_OKAY, 6'h01},
            '{IDX_TRIM, 8'h20, 8'h20, RESP_OKAY, 6'h01}, '{IDX_TRIM, 8'h00, 8'h00, RESP_OKAY, 6'h01},
            '{IDX_FREQ, 8'h01, 8'h01, RESP_OKAY, 6'h02}, '{IDX_FREQ, 8'h02, 8'h02, RESP_OKAY, 6'h04},
            '{IDX_FREQ, 8'h03, 8'h03, RESP_OKAY, 6'h08}, '{IDX_FREQ, 8'h04, 8'h04, RESP_OKAY, 6'h10},
            '{IDX_FREQ, 8'h05, 8'h05, RESP_OKAY, 6'h20}, '{IDX_FREQ, 8'h06, 8'h05, RESP_OKAY, 6'h20},
            '{IDX_FREQ, 8'h07, 8'h05, RESP_OKAY, 6'h20}, '{IDX_FREQ, 8'h00, 8'h00, RESP_OKAY, 6'h01},
            '{IDX_ENABLE, 8'h02, 8'h00, RESP_OKAY, 6'h01}, '{10'h100, 8'hff, 8'h00, RESP_SLVERR, 6'h01}};
        rst = 1'b1;
        {slow, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, tune_update} = 7'h00;
        {s_awaddr, s_araddr, s_wdata, periph_req, sys_clk_sel} = '0;
        {ext_osc_mode_config, tune_value} = '0;
        s_wstrb = 4'hf;
        reset_dut();
        check_reset();
        foreach (rows[i]) begin
            wr_reg(rows[i].idx, rows[i].wr);
            chk("write response", rows[i].resp, resp);
            rd_reg(rows[i].idx);
            chk("read data", rows[i].rd, rd);
            chk("read response", rows[i].resp, resp);
            chk("frequency", rows[i].mhz, nominal_freq_mhz);
        end
        wr_reg(IDX_CTRL3, 8'h00);
        repeat (2) @(posedge clk);
        chk("power select", 0, secondary_power_sel);
        for (int b = 1; b < 8; b++) begin
            exp7 = 7'(1 << (b - 1));
            slow <= b[0];
            periph_req <= exp7;
            @(posedge clk);
            @(negedge clk);
            chk("run early", 0, osc_run);
            @(negedge clk);
            chk("run on demand", exp7, osc_run);
            repeat (10) @(posedge clk);
            rd_reg(IDX_STATUS);
            chk("status ready", {exp7, 1'b0}, rd);
            periph_req <= 7'h00;
            repeat (6) @(posedge clk);
            rd_reg(IDX_STATUS);
            chk("status idle", 0, rd);
        end
        slow <= 1'b0;
        sys_clk_sel <= 7'h01;
        repeat (12) @(posedge clk);
        rd_reg(IDX_STATUS);
        chk("fast start ready", 8'h02, rd);
        sys_clk_sel <= 7'h00;
        ext_osc_mode_config <= 3'h5;
        wr_reg(IDX_ENABLE, 8'hfd);
        repeat (12) @(posedge clk);
        chk("forced run", 7'h7e, osc_run);
        chk("external mode", 5, ext_osc_mode);
        chk("multiplier idle", 0, pll_run);
        chk("peripheral multiplier", 1, periph_ext_use_pll);
        rd_reg(IDX_STATUS);
        chk("forced status", 8'hfc, rd);
        periph_req <= 7'h40;
        repeat (12) @(posedge clk);
        rd_reg(IDX_STATUS);
        chk("multiplier ready", 8'hfd, rd);
        wr_reg(IDX_ENABLE, 8'hfc);
        repeat (12) @(posedge clk);
        chk("peripheral multiplier", 0, periph_ext_use_pll);
        rd_reg(IDX_STATUS);
        chk("multiplier off", 8'hfc, rd);
        wr_reg(IDX_TUNECTL, 8'h80);
        pulse_tune(6'h2a);
        chk("auto trim", 8'h2a, rd);
        wr_reg(IDX_TUNECTL, 8'hc0);
        pulse_tune(6'h15);
        chk("held trim", 8'h2a, rd);
        chk("trim output", 8'h2a, freq_trim);
        chk("tune control", 3, {auto_tune_on, auto_tune_update_hold});
        periph_req <= 7'h00;
        reset_dut();
        check_reset();
        results();
    end
endmodule
bind oest_top oest_checker u_oest_checker (.clk, .rst, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid,
    .s_bresp, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .periph_req, .sys_clk_sel, .osc_ready,
    .pll_locked, .osc_run, .pll_run, .periph_ext_use_pll, .tune_value, .tune_update, .freq_trim,
    .nominal_freq_sel, .nominal_freq_mhz, .auto_tune_on, .auto_tune_update_hold);
